/* File: rtl/lhp_params.svh */
`ifndef LHP_PARAMS_SVH
`define LHP_PARAMS_SVH

// Lane and word widths
`define LHP_LANES 18
`define LHP_IDX_W 16

// Strap codes, taken as {upper three straps, lowest strap}
`define LHP_IM_P16 4'h2
`define LHP_IM_P8 4'h3
`define LHP_IM_P18 4'ha
`define LHP_IM_P9 4'hb
`define LHP_IM_SER 3'h2

// Serial start byte: five code bits, ID bit, select bit, read bit
// Code value is arbitrary
`define LHP_SPI_CODE 5'h0e
`define LHP_SPI_LAST_START 4'h7
`define LHP_SPI_LAST_WORD 4'hf

// Frame head pulse width
`define LHP_CLK_MHZ 100
`define LHP_FRAME_HEAD_PULSE_NS 50
`define LHP_FRAME_HEAD_PULSE_CYC ((`LHP_FRAME_HEAD_PULSE_NS * `LHP_CLK_MHZ + 999) / 1000)

// Reset values of the synchronised pin group
`define LHP_PIN_RST 27'h7000000
`define LHP_CFG_RST 2'h0

`endif

/* File: rtl/lhp_pkg.sv */
package lhp_pkg;
`include "lhp_params.svh"

	typedef enum logic [2:0] {
		LHP_OFF = 3'h0,
		LHP_P8 = 3'h1,
		LHP_P9 = 3'h2,
		LHP_P16 = 3'h3,
		LHP_P18 = 3'h4,
		LHP_SER = 3'h5
	} lhp_mode_type;

	typedef enum logic [1:0] {
		SP_START = 2'h0,
		SP_WRITE = 2'h1,
		SP_READ = 2'h2,
		SP_IGNORE = 2'h3
	} lhp_spi_type;

	typedef enum logic [1:0] {
		RGB6 = 2'h0,
		RGB8 = 2'h1,
		RGB16 = 2'h2,
		RGB18 = 2'h3
	} lhp_rgb_type;

	function automatic lhp_mode_type lhp_mode_dec(input logic [3:0] im);
		if (im[3:1] == `LHP_IM_SER) begin
			return LHP_SER;
		end
		unique case (im)
			`LHP_IM_P16: return LHP_P16;
			`LHP_IM_P8: return LHP_P8;
			`LHP_IM_P18: return LHP_P18;
			`LHP_IM_P9: return LHP_P9;
			default: return LHP_OFF;
		endcase
	endfunction

	function automatic logic [17:0] lhp_rgb_lanes(input lhp_rgb_type m,
		input logic [17:0] l);
		unique case (m)
			RGB6: return {12'h000, l[17:12]};
			RGB8: return {10'h000, l[17:10]};
			RGB16: return {2'h0, l[17:13], l[11:1]};
			RGB18: return l;
		endcase
	endfunction
endpackage

/* File: rtl/lhp_sync.sv */
module lhp_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_q <= INIT;
			q_o <= INIT;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

/* File: rtl/lhp_pixel_cap.sv */
module lhp_pixel_cap import lhp_pkg::*; (
	input wire logic pixel_clock_i,
	input wire logic rstn_i,
	input wire logic [17:0] data_lanes_i,
	input wire logic vsync_n_i,
	input wire logic hsync_n_i,
	input wire logic data_valid_i,
	input wire logic data_valid_polarity_i,
	input wire logic pixel_clock_edge_select_i,
	output logic [20:0] word_o,
	output logic toggle_o
);
	typedef struct packed {
		logic [20:0] word;
		logic tog;
	} lhp_pix_type;

	lhp_pix_type q, d;
	logic [20:0] fall_q;
	logic [1:0] cfg_s;
	logic [20:0] now;

	lhp_sync #(.W(2), .INIT(`LHP_CFG_RST)) u_cfg (
		.clk_i(pixel_clock_i),
		.rstn_i(rstn_i),
		.d_i({data_valid_polarity_i, pixel_clock_edge_select_i}),
		.q_o(cfg_s)
	);

	// Default active level is low; the polarity bit inverts it
	assign now = {vsync_n_i, hsync_n_i, ~(data_valid_i ^ cfg_s[1]),
		data_lanes_i};

	// Falling-edge sample, handed on at the following rising edge
	always_ff @(negedge pixel_clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fall_q <= 21'h000000;
		end else begin
			fall_q <= now;
		end
	end

	always_comb begin
		d = q;
		d.word = cfg_s[0] ? fall_q : now;
		d.tog = ~q.tog;
	end

	always_ff @(posedge pixel_clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign word_o = q.word;
	assign toggle_o = q.tog;
endmodule

/* File: rtl/lhp_host_port.sv */
// Overview of operation
// - Four straps pick parallel or serial mode
// - Upper straps low-high-low select serial port
// - Lowest strap gives serial ID bit
// - Nine and eighteen bit modes: full colour
// - Other modes allow both colour depths
// - Host parallel lane use per mode
// - Pixel port lane use per mode
// - Host accesses only while select low
// - Register select picks index or register
// - Write strobe low starts write cycle
// - Read strobe low starts driven read
// - Write strobe pin is serial clock
// - Serial input sampled on rising clock
// - Serial output launched on rising clock
// - Lanes driven only during reads
// - Pixel data valid when qualifier low
// - Polarity bit inverts qualifier level
// - Edge select picks pixel clock edge
// - Sync inputs time frames and lines
// - Device outputs frame head pulse
// - Active low external reset
// - First memory read returns stale data
// - Memory written only on valid edges
module lhp_host_port import lhp_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [2:0] interface_mode_straps_i,
	input wire logic mode_strap_or_device_code_bit_i,
	input wire logic cs_n_i,
	input wire logic register_select_i,
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_n_o,
	input wire logic [17:0] data_lanes_i,
	output logic [17:0] data_lanes_o,
	output logic data_lanes_oe_n_o,
	input wire logic pixel_clock_i,
	input wire logic vsync_n_i,
	input wire logic hsync_n_i,
	input wire logic data_valid_i,
	input wire logic data_valid_polarity_i,
	input wire logic pixel_clock_edge_select_i,
	input wire logic rgb_enable_i,
	input wire lhp_rgb_type rgb_mode_i,
	input wire logic color_65k_i,
	input wire logic frame_tick_i,
	input wire logic [15:0] status_i,
	input wire logic [17:0] reg_rdata_i,
	output lhp_mode_type host_mode_o,
	output logic wide_format_o,
	output logic [15:0] index_register_o,
	output logic [17:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [17:0] pixel_data_o,
	output logic pixel_valid_o,
	output logic frame_start_o,
	output logic line_start_o,
	output logic frame_head_pulse_o
);
	typedef struct packed {
		lhp_mode_type mode;
		lhp_spi_type sst;
		logic [3:0] cnt;
		logic [15:0] shreg;
		logic [15:0] rdsh;
		logic regsel;
		logic serial_data_out;
		logic second;
		logic [8:0] hold;
		logic rd_act;
		logic [17:0] lanes;
		logic [15:0] index;
		logic [17:0] wdata;
		logic [17:0] rdr;
		logic wr_p;
		logic rd_p;
		logic clk_prev;
		logic rd_prev;
		logic tog_prev;
		logic vs_prev;
		logic hs_prev;
		logic pix_v;
		logic frame_p;
		logic line_p;
		logic [17:0] pix;
		logic [3:0] fcnt;
	} lhp_state_type;

	lhp_state_type q, d;
	logic [26:0] pin_s;
	logic cs_act;
	logic regsel_s;
	logic wr_s;
	logic rd_s;
	logic sdi_s;
	logic [2:0] straps_s;
	logic code_s;
	logic [17:0] lanes_s;
	logic [20:0] pix_word;
	logic pix_tog;
	logic tog_s;

	lhp_sync #(.W(27), .INIT(`LHP_PIN_RST)) u_pins (
		.clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.d_i({cs_n_i, wr_n_i, rd_n_i, register_select_i, serial_data_in_i,
			interface_mode_straps_i, mode_strap_or_device_code_bit_i,
			data_lanes_i}),
		.q_o(pin_s)
	);

	assign cs_act = ~pin_s[26];
	assign wr_s = pin_s[25];
	assign rd_s = pin_s[24];
	assign regsel_s = pin_s[23];
	assign sdi_s = pin_s[22];
	assign straps_s = pin_s[21:19];
	assign code_s = pin_s[18];
	assign lanes_s = pin_s[17:0];

	lhp_pixel_cap u_pix (
		.pixel_clock_i(pixel_clock_i),
		.rstn_i(rstn_i),
		.data_lanes_i(data_lanes_i),
		.vsync_n_i(vsync_n_i),
		.hsync_n_i(hsync_n_i),
		.data_valid_i(data_valid_i),
		.data_valid_polarity_i(data_valid_polarity_i),
		.pixel_clock_edge_select_i(pixel_clock_edge_select_i),
		.word_o(pix_word),
		.toggle_o(pix_tog)
	);

	// Word is held for a whole pixel period, so it is stable once the
	// toggle has crossed
	lhp_sync #(.W(1), .INIT(1'b0)) u_tog (
		.clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.d_i(pix_tog),
		.q_o(tog_s)
	);

	function automatic logic [17:0] lane_in(input lhp_mode_type m,
		input logic [17:0] l);
		unique case (m)
			LHP_P8: return {10'h000, l[17:10]};
			LHP_P9: return {9'h000, l[17:9]};
			LHP_P16: return {2'h0, l[17:10], l[8:1]};
			default: return l;
		endcase
	endfunction

	function automatic logic [17:0] lane_out(input lhp_mode_type m,
		input logic [17:0] w, input logic lo);
		unique case (m)
			LHP_P8: return {lo ? w[7:0] : w[15:8], 10'h000};
			LHP_P9: return {lo ? w[8:0] : w[17:9], 9'h000};
			LHP_P16: return {w[15:8], 1'b0, w[7:0], 1'b0};
			default: return w;
		endcase
	endfunction

	always_comb begin
		logic [15:0] sh;
		logic [17:0] piece;
		logic [17:0] cword;
		logic commit;
		logic creg;
		logic fetch;
		logic pair;
		logic fstart;
		sh = {q.shreg[14:0], sdi_s};
		piece = lane_in(q.mode, lanes_s);
		cword = piece;
		commit = 1'b0;
		creg = regsel_s;
		fetch = 1'b0;
		pair = (q.mode == LHP_P8) || (q.mode == LHP_P9);
		fstart = 1'b0;
		d = q;
		d.wr_p = 1'b0;
		d.rd_p = 1'b0;
		d.pix_v = 1'b0;
		d.frame_p = 1'b0;
		d.line_p = 1'b0;
		d.mode = lhp_mode_dec({straps_s, code_s});
		d.clk_prev = wr_s;
		d.rd_prev = rd_s;
		if (!cs_act) begin
			d.sst = SP_START;
			d.cnt = 4'h0;
			d.second = 1'b0;
			d.rd_act = 1'b0;
		end else if (q.mode == LHP_SER) begin
			// Write strobe pin serves as the serial clock
			if (wr_s && !q.clk_prev) begin
				d.shreg = sh;
				d.cnt = q.cnt + 4'h1;
				unique case (q.sst)
					SP_START: begin
						if (q.cnt == `LHP_SPI_LAST_START) begin
							d.cnt = 4'h0;
							if (sh[7:3] == `LHP_SPI_CODE && sh[2] == code_s) begin
								d.regsel = sh[1];
								if (sh[0]) begin
									d.sst = SP_READ;
									d.rdsh = sh[1] ? q.rdr[15:0] : status_i;
									fetch = sh[1];
								end else begin
									d.sst = SP_WRITE;
								end
							end else begin
								d.sst = SP_IGNORE;
							end
						end
					end
					SP_WRITE: begin
						if (q.cnt == `LHP_SPI_LAST_WORD) begin
							commit = 1'b1;
							creg = q.regsel;
							cword = {2'h0, sh};
						end
					end
					SP_READ: begin
						d.serial_data_out = q.rdsh[15];
						d.rdsh = {q.rdsh[14:0], 1'b0};
						if (q.cnt == `LHP_SPI_LAST_WORD) begin
							d.rdsh = q.regsel ? q.rdr[15:0] : status_i;
							fetch = q.regsel;
						end
					end
					SP_IGNORE: begin
						d.cnt = 4'h0;
					end
				endcase
			end
		end else if (q.mode != LHP_OFF) begin
			// Data is taken as the write strobe returns high
			if (wr_s && !q.clk_prev) begin
				if (pair && !q.second) begin
					d.hold = piece[8:0];
					d.second = 1'b1;
				end else begin
					commit = 1'b1;
					d.second = 1'b0;
					if (q.mode == LHP_P8) begin
						cword = {2'h0, q.hold[7:0], piece[7:0]};
					end else if (q.mode == LHP_P9) begin
						cword = {q.hold, piece[8:0]};
					end
				end
			end
			if (!rd_s && q.rd_prev) begin
				d.rd_act = 1'b1;
				d.lanes = lane_out(q.mode, regsel_s ? q.rdr :
					{2'h0, status_i}, q.second);
			end
			if (rd_s && !q.rd_prev && q.rd_act) begin
				d.rd_act = 1'b0;
				if (pair && !q.second) begin
					d.second = 1'b1;
				end else begin
					d.second = 1'b0;
					fetch = regsel_s;
				end
			end
		end
		if (commit) begin
			if (creg) begin
				d.wdata = cword;
				d.wr_p = 1'b1;
			end else begin
				d.index = cword[15:0];
			end
		end
		// Prefetch: each register read shows the word fetched by the one before; status reads show status_i live
		if (fetch) begin
			d.rdr = reg_rdata_i;
			d.rd_p = 1'b1;
		end
		if (tog_s != q.tog_prev) begin
			d.tog_prev = tog_s;
			d.vs_prev = pix_word[20];
			d.hs_prev = pix_word[19];
			if (rgb_enable_i) begin
				d.frame_p = q.vs_prev && !pix_word[20];
				d.line_p = q.hs_prev && !pix_word[19];
				if (pix_word[18]) begin
					d.pix_v = 1'b1;
					d.pix = lhp_rgb_lanes(rgb_mode_i, pix_word[17:0]);
				end
			end
		end
		fstart = rgb_enable_i ? d.frame_p : frame_tick_i;
		if (fstart) begin
			d.fcnt = 4'(`LHP_FRAME_HEAD_PULSE_CYC);
		end else if (q.fcnt != 4'h0) begin
			d.fcnt = q.fcnt - 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign data_lanes_o = q.lanes;
	assign data_lanes_oe_n_o = ~(q.rd_act && cs_act);
	assign serial_data_out_o = q.serial_data_out;
	assign serial_data_out_oe_n_o = ~(cs_act && q.mode == LHP_SER &&
		q.sst == SP_READ);
	assign host_mode_o = q.mode;
	assign wide_format_o = (q.mode == LHP_P9 || q.mode == LHP_P18) ? 1'b1 :
		~color_65k_i;
	assign index_register_o = q.index;
	assign reg_wdata_o = q.wdata;
	assign reg_wr_o = q.wr_p;
	assign reg_rd_o = q.rd_p;
	assign pixel_data_o = q.pix;
	assign pixel_valid_o = q.pix_v;
	assign frame_start_o = q.frame_p;
	assign line_start_o = q.line_p;
	assign frame_head_pulse_o = (q.fcnt != 4'h0);

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	lanes_idle_a: assert property (!cs_act |=> data_lanes_oe_n_o)
		else $error("lanes driven while deselected");
	read_drive_a: assert property (!data_lanes_oe_n_o |-> !$past(rd_s))
		else $error("lanes driven outside a read");
	off_mode_a: assert property (q.mode == LHP_OFF |=> !reg_wr_o)
		else $error("write accepted with bad straps");
	serial_pick_a: assert property (straps_s == `LHP_IM_SER |=>
		host_mode_o == LHP_SER)
		else $error("serial straps not decoded");
	full_color_a: assert property ((host_mode_o == LHP_P9 ||
		host_mode_o == LHP_P18) |-> wide_format_o)
		else $error("reduced depth in 9/18-bit mode");
	sdo_drive_a: assert property (!serial_data_out_oe_n_o |->
		host_mode_o == LHP_SER && cs_act)
		else $error("serial output driven out of mode");
	frame_head_pulse_width_a: assert property ($rose(frame_head_pulse_o) |->
		frame_head_pulse_o[*5] ##1 !frame_head_pulse_o)
		else $error("frame head pulse width wrong");
	write_cs_a: assert property (reg_wr_o |-> $past(cs_act))
		else $error("write taken while deselected");
	pix_valid_a: assert property (pixel_valid_o |-> $past(rgb_enable_i))
		else $error("pixel stored while port disabled");
	prefetch_a: assert property (reg_rd_o |-> q.rdr == $past(reg_rdata_i))
		else $error("read word not prefetched");

	serial_wr_c: cover property (reg_wr_o && host_mode_o == LHP_SER);
	pair_wr_c: cover property (reg_wr_o && host_mode_o == LHP_P8);
	pix_c: cover property (pixel_valid_o);
	frame_head_pulse_c: cover property ($rose(frame_head_pulse_o));
endmodule

/* File: testbench/lhp_host_model.sv */
module lhp_host_model (
	input wire logic clk_i,
	input wire logic [17:0] bus_i,
	input wire logic oe_n_i,
	input wire logic sdo_i,
	output logic cs_n_o,
	output logic rs_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic sdi_o,
	output logic [17:0] lanes_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cs_n_o = 1'b1;
		rs_o = 1'b0;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		sdi_o = 1'b0;
		lanes_o = 18'h00000;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Data held 40 ns past strobe release, then scrambled
	task automatic wr(input logic sel, input logic r, input logic [17:0] d);
		cs_n_o <= !sel;
		rs_o <= r;
		lanes_o <= d;
		wr_n_o <= 1'b0;
		tick(6);
		wr_n_o <= 1'b1;
		tick(4);
		lanes_o <= ~d;
		tick(4);
	endtask
	task automatic desel();
		cs_n_o <= 1'b1;
		tick(6);
	endtask
	task automatic rd(input logic r, output logic [17:0] d, output logic oe);
		cs_n_o <= 1'b0;
		rs_o <= r;
		rd_n_o <= 1'b0;
		tick(6);
		d = bus_i;
		oe = oe_n_i;
		rd_n_o <= 1'b1;
		tick(4);
	endtask
	// Serial clock idles high and runs only inside the frame
	task automatic spi(input logic [7:0] s, input logic [15:0] w,
		output logic [15:0] r);
		logic [23:0] b;
		b = {s, w};
		r = 16'h0000;
		cs_n_o <= 1'b0;
		tick(2);
		for (int i = 23; i >= 0; i--) begin
			sdi_o <= b[i];
			wr_n_o <= 1'b0;
			tick(5);
			wr_n_o <= 1'b1;
			tick(5);
			// Bit launched at this rise, taken before the next one
			if (i < 16) r = {r[14:0], sdo_i};
		end
		sdi_o <= ~b[0];
		cs_n_o <= 1'b1;
		tick(6);
	endtask
endmodule

/* File: testbench/test_lhp_host_port.sv */
`include "lhp_params.svh"
module test_lhp_host_port import lhp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic pixel_clock_i = 1'b0;
	logic pix_run = 1'b1;
	logic [3:0] im = 4'ha;
	logic vs_n = 1'b1, hs_n = 1'b1, dv = 1'b1, pol = 1'b0, esel = 1'b0;
	logic rgb_en = 1'b0, c65k = 1'b0, ftick = 1'b0, pix_on = 1'b0;
	lhp_rgb_type rgb_mode = RGB6;
	logic [15:0] status = 16'h0000;
	logic [17:0] rdata = 18'h00000, pix_l = 18'h00000, bus;
	logic cs_n, rs, wr_n, rd_n, serial_data_in, serial_data_out, sdo_oe_n, oe_n, reg_wr, reg_rd;
	logic pvalid, fs, ls, fh, wide, fh_q = 1'b0;
	logic [17:0] dout, host_l, wdata, pdata;
	logic [15:0] idx;
	lhp_mode_type mode;
	logic [17:0] exp_reg[$], exp_pix[$];
	int miscompares = 0, total_checks = 0;
	int n_rd = 0, n_fs = 0, n_ls = 0, n_fh = 0;

	assign bus = !oe_n ? dout : (pix_on ? pix_l : host_l);
	always #5 sys_clk_i = ~sys_clk_i;
	always begin
		#32;
		if (pix_run || pixel_clock_i) pixel_clock_i = ~pixel_clock_i;
	end

	lhp_host_port u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
		.interface_mode_straps_i(im[3:1]),
		.mode_strap_or_device_code_bit_i(im[0]), .cs_n_i(cs_n),
		.register_select_i(rs), .wr_n_i(wr_n), .rd_n_i(rd_n),
		.serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out),
		.serial_data_out_oe_n_o(sdo_oe_n), .data_lanes_i(bus),
		.data_lanes_o(dout), .data_lanes_oe_n_o(oe_n),
		.pixel_clock_i(pixel_clock_i), .vsync_n_i(vs_n), .hsync_n_i(hs_n),
		.data_valid_i(dv), .data_valid_polarity_i(pol),
		.pixel_clock_edge_select_i(esel), .rgb_enable_i(rgb_en),
		.rgb_mode_i(rgb_mode), .color_65k_i(c65k), .frame_tick_i(ftick),
		.status_i(status), .reg_rdata_i(rdata), .host_mode_o(mode),
		.wide_format_o(wide), .index_register_o(idx), .reg_wdata_o(wdata),
		.reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .pixel_data_o(pdata),
		.pixel_valid_o(pvalid), .frame_start_o(fs), .line_start_o(ls),
		.frame_head_pulse_o(fh));
	lhp_host_model u_host (.clk_i(sys_clk_i), .bus_i(bus), .oe_n_i(oe_n),
		.sdo_i(sdo_oe_n ? ~serial_data_out : serial_data_out),
		.cs_n_o(cs_n), .rs_o(rs), .wr_n_o(wr_n), .rd_n_o(rd_n),
		.sdi_o(serial_data_in), .lanes_o(host_l));

	task automatic check(input string what, input logic [17:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	function automatic logic [2:0] exp_mode(input logic [3:0] v);
		if (v[3:1] == 3'h2) return LHP_SER;
		case (v)
			4'h2: return LHP_P16;
			4'h3: return LHP_P8;
			4'ha: return LHP_P18;
			4'hb: return LHP_P9;
			default: return LHP_OFF;
		endcase
	endfunction
	function automatic logic [17:0] pmap(input logic [1:0] m, logic [17:0] l);
		case (m)
			2'h0: return {12'h000, l[17:12]};
			2'h1: return {10'h000, l[17:10]};
			2'h2: return {2'h0, l[17:13], l[11:1]};
			default: return l;
		endcase
	endfunction
	// Drive on the edge opposite the capture edge; last pixel is idle
	task automatic burst(input int n);
		logic [17:0] l;
		logic v;
		// Let new edge and polarity settings cross before pixels count
		rgb_en <= 1'b0;
		pix_run = 1'b1;
		repeat (3) @(posedge pixel_clock_i);
		tick(6);
		rgb_en <= 1'b1;
		for (int i = 0; i < n; i++) begin
			if (esel) @(posedge pixel_clock_i); else @(negedge pixel_clock_i);
			l = 18'($urandom);
			v = (i == n - 1) ? ~pol : 1'($urandom);
			vs_n <= (i != 1);
			hs_n <= (i != 1);
			pix_l <= l;
			dv <= v;
			if (v == pol) exp_pix.push_back(pmap(rgb_mode, l));
		end
		if (esel) @(negedge pixel_clock_i); else @(posedge pixel_clock_i);
		pix_run = 1'b0;
		tick(20);
	endtask

	always @(negedge sys_clk_i) begin
		if (reg_wr === 1'b1)
			check("wdata", wdata, exp_reg.size() ? exp_reg.pop_front() : 'x);
		if (pvalid === 1'b1)
			check("pixel", pdata, exp_pix.size() ? exp_pix.pop_front() : 'x);
		n_rd += (reg_rd === 1'b1);
		n_fs += (fs === 1'b1);
		n_ls += (ls === 1'b1);
		n_fh += (fh === 1'b1 && fh_q !== 1'b1);
		fh_q <= fh;
	end

	initial begin
		logic [17:0] d, a, b, got;
		logic [15:0] w, e_idx, r;
		logic o;
		void'($urandom(32'h6a72e26b));
		tick(10);
		rstn_i <= 1'b1;
		pix_run = 1'b0;
		c65k <= 1'b1;
		tick(6);
		for (int k = 0; k < 16; k++) begin
			im <= 4'(k);
			tick(6);
			check("mode", 18'(mode), 18'(exp_mode(4'(k))));
			if (exp_mode(4'(k)) != LHP_OFF)
				check("wide", 18'(wide), 18'(k inside {10, 11}));
		end
		u_host.wr(1'b1, 1'b1, 18'h15a5a);
		u_host.desel();
		im <= 4'ha;
		tick(6);
		d = 18'($urandom);
		u_host.wr(1'b0, 1'b1, d);
		exp_reg.push_back(d);
		u_host.wr(1'b1, 1'b1, d);
		a = 18'($urandom);
		u_host.wr(1'b1, 1'b0, a);
		check("index", 18'(idx), 18'(a[15:0]));
		b = 18'($urandom);
		rdata <= b;
		u_host.rd(1'b1, got, o);
		u_host.rd(1'b1, got, o);
		check("read", got, b);
		check("lanes driven", 18'(o), 18'h0);
		check("lanes free", 18'(oe_n), 18'h1);
		w = 16'($urandom);
		status <= w;
		u_host.rd(1'b0, got, o);
		u_host.desel();
		check("status", 18'(got[15:0]), 18'(w));
		check("fetches", 18'(n_rd), 18'h2);
		im <= 4'h2;
		tick(6);
		w = 16'($urandom);
		u_host.wr(1'b1, 1'b0, {w[15:8], 1'b1, w[7:0], 1'b0});
		u_host.desel();
		check("p16 index", 18'(idx), 18'(w));
		for (int k = 0; k < 2; k++) begin
			im <= k ? 4'h3 : 4'hb;
			tick(6);
			a = 18'($urandom);
			b = 18'($urandom);
			exp_reg.push_back(k ? {2'h0, a[17:10], b[17:10]} : {a[17:9], b[17:9]});
			u_host.wr(1'b1, 1'b1, a);
			u_host.wr(1'b1, 1'b1, b);
			u_host.desel();
		end
		e_idx = w;
		for (int k = 0; k < 3; k++) begin
			im <= (k == 2) ? 4'h4 : 4'h5;
			tick(6);
			w = 16'($urandom);
			if (k != 1) e_idx = w;
			u_host.spi({`LHP_SPI_CODE, k == 0, 2'b00}, w, r);
			check("serial index", 18'(idx), 18'(e_idx));
			check("sdo free", 18'(sdo_oe_n), 18'h1);
		end
		w = 16'($urandom);
		exp_reg.push_back({2'h0, w});
		u_host.spi({`LHP_SPI_CODE, 3'b010}, w, r);
		u_host.spi({`LHP_SPI_CODE, 3'b001}, 16'h0000, r);
		check("serial status", 18'(r), 18'(status));
		check("sdo released", 18'(sdo_oe_n), 18'h1);
		rgb_en <= 1'b1;
		pix_on <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			rgb_mode <= lhp_rgb_type'(k);
			pol <= k[0];
			esel <= k[1];
			dv <= !k[0];
			tick(4);
			burst(12);
		end
		// Internal frame tick only starts a pulse while the pixel port is off
		rgb_en <= 1'b0;
		ftick <= 1'b1;
		tick(1);
		ftick <= 1'b0;
		tick(20);
		check("frames", 18'(n_fs), 18'h4);
		check("lines", 18'(n_ls), 18'h4);
		check("frame heads", 18'(n_fh), 18'h5);
		check("left over", 18'(exp_reg.size() + exp_pix.size()), 18'h0);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		miscompares++;
		end_sim();
	end
endmodule
